// ===== rtl/gpio_cfg_pkg.sv
/*
 * Shared constants for the link pin configuration block: register offsets,
 * field positions, reset values, mode codes and the mode decoder.
 * Assumes an 8-bit register port addressed by printed byte offsets.
 */
package gpio_cfg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PIN_N = 3;
    localparam int SET_N = 2;

    // Register offsets
    localparam logic [7:0] OFF_CONTROL = 8'h04;
    localparam logic [7:0] OFF_GEN_STATUS = 8'h0c;
    localparam logic [7:0] OFF_PIN0_CFG = 8'h0d;
    localparam logic [7:0] OFF_PIN12_CFG = 8'h0e;
    localparam logic [7:0] OFF_PIN_INPUT = 8'h1f;

    // Field positions
    localparam int CTRL_PORT_SEL_BIT = 0;
    localparam int CTRL_ERR_RESET_BIT = 5;
    localparam int STAT_LINK_DETECT_BIT = 0;
    localparam int STAT_LINK_LOST_BIT = 4;
    localparam int CFG_OUT_VAL_BIT = 3;
    localparam int CFG_NIBBLE_W = 4;
    localparam int CFG_HI_NIBBLE_LSB = 4;

    // Values after reset
    localparam logic [3:0] CFG_RESET = 4'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic PORT_SEL_RESET = 1'b0;

    // Revision field value is arbitrary
    localparam logic [3:0] REVISION_DEFAULT = 4'h1;

    // Full mode codes; the first two roles only look at the low two bits
    localparam logic [1:0] MODE_LO_FUNC = 2'h0;
    localparam logic [1:0] MODE_LO_HIZ = 2'h2;
    localparam logic [2:0] MODE_OUT = 3'h1;
    localparam logic [2:0] MODE_IN = 3'h3;
    localparam logic [2:0] MODE_RHOLD = 3'h5;
    localparam logic [2:0] MODE_RDEF = 3'h7;

    typedef enum logic [2:0] {
        ROLE_FUNC = 3'b000,
        ROLE_HIZ = 3'b001,
        ROLE_OUT = 3'b010,
        ROLE_IN = 3'b011,
        ROLE_RHOLD = 3'b100,
        ROLE_RDEF = 3'b101
    } pin_role_e;

    // Mode field to pin role
    function automatic pin_role_e decode_mode(input logic [2:0] mode);
        pin_role_e role;
        role = ROLE_FUNC;
        if (mode[1:0] == MODE_LO_FUNC) begin
            role = ROLE_FUNC;
        end else if (mode[1:0] == MODE_LO_HIZ) begin
            role = ROLE_HIZ;
        end else if (mode == MODE_OUT) begin
            role = ROLE_OUT;
        end else if (mode == MODE_IN) begin
            role = ROLE_IN;
        end else if (mode == MODE_RHOLD) begin
            role = ROLE_RHOLD;
        end else begin
            role = ROLE_RDEF;
        end
        return role;
    endfunction : decode_mode

endpackage : gpio_cfg_pkg

// ===== rtl/gpio_pin_ctrl.sv
/*
 * One configurable pin: turns a mode field and an output value bit into
 * pin drive, enable, functional input and input status, all registered.
 * Assumes remote value and link state are synchronous to core_clk.
 */
`timescale 1ns/1ps
module gpio_pin_ctrl
    import gpio_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [2:0] mode,
    input wire logic out_val,
    input wire logic remote_val,
    input wire logic link_up,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic func_in,
    output logic in_status
);

    logic pin_out_q, pin_out_d;
    logic pin_oe_q, pin_oe_d;
    logic held_q, held_d;
    logic func_q, func_d;
    logic in_q, in_d;
    pin_role_e role;

    // Next drive from the decoded role
    always_comb begin
        role = decode_mode(mode);
        held_d = link_up ? remote_val : held_q; // Last value seen on link
        pin_out_d = 1'b0;
        pin_oe_d = 1'b0;
        func_d = 1'b0;
        in_d = pin_in;
        unique case (role)
            ROLE_FUNC: begin
                func_d = pin_in;
            end
            ROLE_HIZ: begin
                pin_oe_d = 1'b0;
            end
            ROLE_OUT: begin
                pin_oe_d = 1'b1;
                pin_out_d = out_val;
            end
            ROLE_IN: begin
                pin_oe_d = 1'b0;
            end
            ROLE_RHOLD: begin
                pin_oe_d = 1'b1;
                pin_out_d = link_up ? remote_val : held_q;
            end
            ROLE_RDEF: begin
                pin_oe_d = 1'b1;
                pin_out_d = link_up ? remote_val : out_val;
            end
        endcase
    end

    // Registers; reset leaves the pin undriven
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
            held_q <= 1'b0;
            func_q <= 1'b0;
            in_q <= 1'b0;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
            held_q <= held_d;
            func_q <= func_d;
            in_q <= in_d;
        end
    end

    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;
    assign func_in = func_q;
    assign in_status = in_q;

endmodule : gpio_pin_ctrl

// ===== rtl/link_gpio_mode_config.sv
/*
 * Pin configuration registers for a serial-link bridge: three pins on the
 * primary set and three on the second set, with remote-driven modes and a
 * sticky link-lost flag per port.
 * Assumes a plain register port with read data one cycle after the strobe,
 * and link state and remote pin values synchronous to core_clk.
 * The error reset clears the lost flags of both ports; the CRC and BIST
 * bits of the status byte are not kept and read 0. Reads and writes
 * follow the port select, except the pin input byte, which shows both.
 */
`timescale 1ns/1ps

// Overview of operation
// - Local output bit drives pin in output mode
// - Decode mode field into six pin roles
// - Mode 101 drives remote value, holds on loss
// - Mode 111 drives remote value, local on loss
// - Port select steers config writes to second set
// - Sticky link-lost flag cleared by error reset
module link_gpio_mode_config
    import gpio_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    // Register port
    input wire logic [gpio_cfg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gpio_cfg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gpio_cfg_pkg::DATA_W-1:0] reg_rdata,
    // Link presence and remote values from the far end
    input wire logic link0_up,
    input wire logic link1_up,
    input wire logic [gpio_cfg_pkg::PIN_N-1:0] remote0_val,
    input wire logic [gpio_cfg_pkg::PIN_N-1:0] remote1_val,
    // Primary pin set
    input wire logic [gpio_cfg_pkg::PIN_N-1:0] local_pin_in,
    output logic [gpio_cfg_pkg::PIN_N-1:0] local_pin_out,
    output logic [gpio_cfg_pkg::PIN_N-1:0] local_pin_oe,
    // Second pin set
    input wire logic [gpio_cfg_pkg::PIN_N-1:0] second_set_pin_in,
    output logic [gpio_cfg_pkg::PIN_N-1:0] second_set_pin_out,
    output logic [gpio_cfg_pkg::PIN_N-1:0] second_set_pin_oe,
    // Functional input paths, zero unless the pin is in that mode
    output logic [gpio_cfg_pkg::PIN_N-1:0] local_func_in,
    output logic [gpio_cfg_pkg::PIN_N-1:0] second_set_func_in
);

    import gpio_cfg_pkg::*;

    // Config nibbles indexed by set then pin: {out_val, mode[2:0]}
    logic [SET_N-1:0][PIN_N-1:0][3:0] cfg_q, cfg_d;
    logic second_port_select_q, second_port_select_d;
    logic [SET_N-1:0] lost_q, lost_d;
    logic [SET_N-1:0] link_prev_q, link_prev_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;

    // Per-set views of links, remote values and pin inputs
    logic [SET_N-1:0] link_up;
    logic [SET_N-1:0][PIN_N-1:0] remote_val;
    logic [SET_N-1:0][PIN_N-1:0] pin_in_all;
    // Outputs of the pin controllers, by set then pin
    logic [SET_N-1:0][PIN_N-1:0] pin_out_all;
    logic [SET_N-1:0][PIN_N-1:0] pin_oe_all;
    logic [SET_N-1:0][PIN_N-1:0] func_all;
    logic [SET_N-1:0][PIN_N-1:0] in_stat_all;
    logic sel;
    logic err_reset;

    // Pack the two pin sets so one loop serves both
    assign link_up = {link1_up, link0_up};
    assign remote_val = {remote1_val, remote0_val};
    assign pin_in_all = {second_set_pin_in, local_pin_in};
    assign local_pin_out = pin_out_all[0];
    assign local_pin_oe = pin_oe_all[0];
    assign second_set_pin_out = pin_out_all[1];
    assign second_set_pin_oe = pin_oe_all[1];
    assign local_func_in = func_all[0];
    assign second_set_func_in = func_all[1];

    // Software view follows the selected set, except the pin input byte
    assign sel = second_port_select_q;
    assign err_reset = reg_wr && (reg_addr == OFF_CONTROL) &&
                       reg_wdata[CTRL_ERR_RESET_BIT];

    // One controller per pin of each set
    for (genvar s = 0; s < SET_N; s++) begin : g_set
        for (genvar p = 0; p < PIN_N; p++) begin : g_pin
            gpio_pin_ctrl u_pin (
                .core_clk(core_clk),
                .srst(srst),
                .mode(cfg_q[s][p][2:0]),
                .out_val(cfg_q[s][p][CFG_OUT_VAL_BIT]),
                .remote_val(remote_val[s][p]),
                .link_up(link_up[s]),
                .pin_in(pin_in_all[s][p]),
                .pin_out(pin_out_all[s][p]),
                .pin_oe(pin_oe_all[s][p]),
                .func_in(func_all[s][p]),
                .in_status(in_stat_all[s][p])
            );
        end
    end

    // Config writes land in whichever set the port select points at
    always_comb begin
        cfg_d = cfg_q;
        second_port_select_d = second_port_select_q;

        // Writes never stall; one strobe updates one register
        if (reg_wr) begin
            unique case (reg_addr)
                // Control write also carries the error reset strobe
                OFF_CONTROL: begin
                    second_port_select_d = reg_wdata[CTRL_PORT_SEL_BIT];
                end
                // Revision half of this byte is read-only
                OFF_PIN0_CFG: begin
                    cfg_d[sel][0] = reg_wdata[3:0];
                end
                // Pin 1 in the low nibble, pin 2 in the high one
                OFF_PIN12_CFG: begin
                    cfg_d[sel][1] = reg_wdata[3:0];
                    cfg_d[sel][2] = reg_wdata[7:4];
                end
                default: begin
                    // Unmapped or read-only offsets ignore writes
                end
            endcase
        end
    end

    // Config registers; every pin starts as functional input, value low
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int s = 0; s < SET_N; s++) begin
                for (int p = 0; p < PIN_N; p++) begin
                    cfg_q[s][p] <= CFG_RESET;
                end
            end
            second_port_select_q <= PORT_SEL_RESET;
        end else begin
            cfg_q <= cfg_d;
            second_port_select_q <= second_port_select_d;
        end
    end

    // Loss is a registered falling edge of link presence, per port
    always_comb begin
        link_prev_d = link_up;
        lost_d = lost_q;

        // Error reset clears both ports; a new loss still wins
        if (err_reset) begin
            lost_d = '0;
        end
        // Only a 1-to-0 step counts; a link never up sets nothing
        for (int s = 0; s < SET_N; s++) begin
            if (link_prev_q[s] && !link_up[s]) begin
                lost_d[s] = 1'b1;
            end
        end
    end

    // Link-lost flags and the previous link level
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lost_q <= '0;
            // Treat link as down so a dead link at reset sets no flag
            link_prev_q <= '0;
        end else begin
            lost_q <= lost_d;
            link_prev_q <= link_prev_d;
        end
    end

    // Read mux; data stands for one cycle and is zero otherwise
    always_comb begin
        rdata_d = RDATA_RESET;

        if (reg_rd) begin
            unique case (reg_addr)
                // Error reset bit always reads back as zero
                OFF_CONTROL: begin
                    rdata_d[CTRL_PORT_SEL_BIT] = second_port_select_q;
                end
                // Status of the selected port; CRC and BIST bits read 0
                OFF_GEN_STATUS: begin
                    rdata_d[STAT_LINK_LOST_BIT] = lost_q[sel];
                    rdata_d[STAT_LINK_DETECT_BIT] = link_up[sel];
                end
                // Revision sits above the pin 0 nibble
                OFF_PIN0_CFG: begin
                    rdata_d = {REVISION_DEFAULT, cfg_q[sel][0]};
                end
                // Same nibble order as on write
                OFF_PIN12_CFG: begin
                    rdata_d = {cfg_q[sel][2], cfg_q[sel][1]};
                end
                // Both sets at once, so no port select is needed here
                OFF_PIN_INPUT: begin
                    rdata_d = {2'h0, in_stat_all[1], in_stat_all[0]};
                end
                default: begin
                    rdata_d = RDATA_RESET; // Unmapped reads give zero
                end
            endcase
        end
    end

    // Read data register; cleared between reads so stale data never shows
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_q <= RDATA_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Read data straight from its register
    assign reg_rdata = rdata_q;

endmodule : link_gpio_mode_config

// ===== tb/link_gpio_properties.sv
/* Port assertions for the link pin configuration block.
   Assumes register port, links and remote values all run on core_clk. */
`timescale 1ns/1ps
module link_gpio_props
    import gpio_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [gpio_cfg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gpio_cfg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [gpio_cfg_pkg::DATA_W-1:0] reg_rdata,
    input wire logic link0_up,
    input wire logic [gpio_cfg_pkg::PIN_N-1:0] remote0_val,
    input wire logic [gpio_cfg_pkg::PIN_N-1:0] local_pin_out,
    input wire logic [gpio_cfg_pkg::PIN_N-1:0] local_pin_oe,
    input wire logic [gpio_cfg_pkg::PIN_N-1:0] second_set_pin_out,
    input wire logic [gpio_cfg_pkg::PIN_N-1:0] second_set_pin_oe,
    input wire logic [gpio_cfg_pkg::PIN_N-1:0] local_func_in,
    input wire logic [gpio_cfg_pkg::PIN_N-1:0] second_set_func_in
);
    logic sel_q, sel_d;
    logic [3:0] nib_q, nib_d;
    // Shadow of port select and primary pin 0 nibble, seen from the bus
    always_comb begin
        sel_d = sel_q;
        nib_d = nib_q;
        if (reg_wr && reg_addr == OFF_CONTROL) begin
            sel_d = reg_wdata[CTRL_PORT_SEL_BIT];
        end
        if (reg_wr && reg_addr == OFF_PIN0_CFG && !sel_q) begin
            nib_d = reg_wdata[3:0];
        end
        if (srst) begin
            sel_d = PORT_SEL_RESET;
            nib_d = CFG_RESET;
        end
    end
    // Shadow registers
    always_ff @(posedge core_clk) begin
        sel_q <= sel_d;
        nib_q <= nib_d;
    end
    default clocking cb @(posedge core_clk); endclocking
    sequence sel_wr_s;
        reg_wr && reg_addr == OFF_PIN0_CFG && sel_q &&
            reg_wdata[2:0] == MODE_OUT;
    endsequence
    sequence held_s;
        nib_q[2:0] == MODE_RHOLD && link0_up ##1
            nib_q[2:0] == MODE_RHOLD && !link0_up;
    endsequence
    reset_quiet_a:
        assert property (srst |=> local_pin_oe == 3'h0 &&
            second_set_pin_oe == 3'h0 && reg_rdata == 8'h00)
        else $error("outputs live after reset");
    func_oe_excl_a:
        assert property (disable iff (srst)
            (local_pin_oe & local_func_in) == 3'h0 &&
            (second_set_pin_oe & second_set_func_in) == 3'h0)
        else $error("driven pin also passes functional input");
    out_mode_a:
        assert property (disable iff (srst) nib_q[2:0] == MODE_OUT |=>
            local_pin_oe[0] && local_pin_out[0] == $past(nib_q[3]))
        else $error("output mode not driving value bit");
    second_set_a:
        assert property (disable iff (srst) sel_wr_s |-> ##2
            second_set_pin_oe[0] && $stable(local_pin_oe) &&
            second_set_pin_out[0] == $past(reg_wdata[CFG_OUT_VAL_BIT], 2))
        else $error("second set write misrouted");
    hiz_mode_a:
        assert property (disable iff (srst)
            nib_q[1:0] == MODE_LO_HIZ |=> !local_pin_oe[0])
        else $error("high impedance mode drives pin");
    remote_default_a:
        assert property (disable iff (srst)
            nib_q[2:0] == MODE_RDEF && !link0_up |=>
            local_pin_oe[0] && local_pin_out[0] == $past(nib_q[3]))
        else $error("default mode ignores value bit on loss");
    remote_hold_a:
        assert property (disable iff (srst) held_s |=>
            local_pin_oe[0] && local_pin_out[0] == $past(remote0_val[0], 2))
        else $error("hold mode lost last remote value");
endmodule : link_gpio_props

bind link_gpio_mode_config link_gpio_props link_gpio_props_inst (
    .core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
    .link0_up, .remote0_val, .local_pin_out, .local_pin_oe,
    .second_set_pin_out, .second_set_pin_oe, .local_func_in,
    .second_set_func_in
);

// ===== tb/far_deser_model.sv
/* Far-end deserializer: link presence and remote pin values per port.
   Assumes the bench commands it on core_clk. */
`timescale 1ns/1ps
module far_deser_model (
    input wire logic core_clk,
    input wire logic [1:0] link_cmd,
    input wire logic [5:0] val_cmd,
    output logic link0_up,
    output logic link1_up,
    output logic [2:0] remote0_val,
    output logic [2:0] remote1_val
);
    // A dead link scrambles its values so a stale copy never passes
    always_ff @(posedge core_clk) begin
        link0_up <= link_cmd[0];
        link1_up <= link_cmd[1];
        remote0_val <= link_cmd[0] ? val_cmd[2:0] : ~remote0_val;
        remote1_val <= link_cmd[1] ? val_cmd[5:3] : ~remote1_val;
    end
endmodule : far_deser_model

// ===== tb/tb.sv
/* Self-checking bench for the link pin configuration block.
   Assumes the far-end model and the bound checker are compiled first. */
`timescale 1ns/1ps
module tb;
    import gpio_cfg_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [1:0] link_cmd = 2'h3;
    logic [5:0] val_cmd = 6'h00;
    logic link0_up, link1_up;
    logic [2:0] remote0_val, remote1_val, lpo, lpoe, spo, spoe, lfi, sfi;
    logic [2:0] lpi = 3'h0;
    logic [2:0] spi = 3'h0;
    logic [3:0] cfg [2][3];
    logic [31:0] r;
    int fails = 0;
    int checked = 0;
    int seed = 32'h03f3;
    always #4 core_clk = ~core_clk;
    link_gpio_mode_config link_gpio_mode_config_inst (.core_clk(core_clk),
        .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .link0_up(link0_up), .link1_up(link1_up), .remote0_val(remote0_val),
        .remote1_val(remote1_val), .local_pin_in(lpi), .local_pin_out(lpo),
        .local_pin_oe(lpoe), .second_set_pin_in(spi),
        .second_set_pin_out(spo), .second_set_pin_oe(spoe),
        .local_func_in(lfi), .second_set_func_in(sfi));
    far_deser_model far_deser_model_inst (.core_clk(core_clk),
        .link_cmd(link_cmd), .val_cmd(val_cmd), .link0_up(link0_up),
        .link1_up(link1_up), .remote0_val(remote0_val),
        .remote1_val(remote1_val));
    task automatic give_verdict();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, e);
        @(posedge core_clk);
    endtask : rd
    // Returns {oe, out, func}; links held up in the random phase
    function automatic logic [2:0] exp_pin(input logic [3:0] n,
        input logic rv, input logic pin);
        if (n[1:0] == 2'h0) return {2'b00, pin};
        if (n[2:0] == 3'h1) return {1'b1, n[3], 1'b0};
        if (n[2:0] == 3'h5 || n[2:0] == 3'h7) return {1'b1, rv, 1'b0};
        return 3'b000;
    endfunction : exp_pin
    task automatic pins();
        logic [2:0] e;
        @(negedge core_clk);
        for (int p = 0; p < 3; p++) begin
            e = exp_pin(cfg[0][p], remote0_val[p], lpi[p]);
            chk({6'h0, lpoe[p], lfi[p]}, {6'h0, e[2], e[0]});
            if (e[2]) chk({7'h0, lpo[p]}, {7'h0, e[1]});
            e = exp_pin(cfg[1][p], remote1_val[p], spi[p]);
            chk({6'h0, spoe[p], sfi[p]}, {6'h0, e[2], e[0]});
            if (e[2]) chk({7'h0, spo[p]}, {7'h0, e[1]});
        end
        @(posedge core_clk);
    endtask : pins
    task automatic do_reset();
        srst <= 1'b1;
        foreach (cfg[a, b]) cfg[a][b] = 4'h0;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
    endtask : do_reset
    // Watchdog near 7500 cycles, far past the few hundred the tests need
    initial begin
        #60000;
        fails++;
        give_verdict();
    end
    initial begin
        do_reset();
        rd(OFF_PIN0_CFG, {REVISION_DEFAULT, CFG_RESET});
        rd(OFF_PIN12_CFG, 8'h00);
        wr(8'h55, 8'hff);
        rd(8'h55, RDATA_RESET);
        pins();
        // Every mode on pin 0 of both sets, the rest random
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            val_cmd <= r[5:0];
            lpi <= r[8:6];
            spi <= r[11:9];
            wr(OFF_CONTROL, {7'h0, i[3]});
            cfg[i[3]][0] = {r[13], i[2:0]};
            cfg[i[3]][1] = r[17:14];
            cfg[i[3]][2] = r[21:18];
            wr(OFF_PIN0_CFG, {r[31:28], cfg[i[3]][0]});
            wr(OFF_PIN12_CFG, {cfg[i[3]][2], cfg[i[3]][1]});
            rd(OFF_PIN0_CFG, {REVISION_DEFAULT, cfg[i[3]][0]});
            rd(OFF_PIN12_CFG, {cfg[i[3]][2], cfg[i[3]][1]});
            rd(OFF_CONTROL, {7'h0, i[3]});
            rd(OFF_PIN_INPUT, {2'h0, spi, lpi});
            pins();
        end
        // Link loss with default and hold modes swapped between pins
        wr(OFF_CONTROL, 8'h00);
        val_cmd <= 6'h03;
        for (int k = 0; k < 2; k++) begin
            link_cmd <= 2'h3;
            wr(OFF_PIN0_CFG, k ? 8'h05 : 8'h07);
            wr(OFF_PIN12_CFG, k ? 8'h17 : 8'h15);
            repeat (2) @(posedge core_clk);
            link_cmd <= 2'h2;
            repeat (4) @(posedge core_clk);
            @(negedge core_clk);
            chk({6'h0, lpo[1:0]}, k ? 8'h01 : 8'h02);
            @(posedge core_clk);
        end
        rd(OFF_GEN_STATUS, 8'h10);
        link_cmd <= 2'h3;
        repeat (3) @(posedge core_clk);
        rd(OFF_GEN_STATUS, 8'h11);
        wr(OFF_CONTROL, 8'h20);
        rd(OFF_GEN_STATUS, 8'h01);
        // Second port: its own flag, seen only with the select set
        wr(OFF_CONTROL, 8'h01);
        link_cmd <= 2'h1;
        repeat (3) @(posedge core_clk);
        rd(OFF_GEN_STATUS, 8'h10);
        wr(OFF_CONTROL, 8'h21);
        rd(OFF_GEN_STATUS, 8'h00);
        link_cmd <= 2'h3;
        do_reset();
        rd(OFF_PIN12_CFG, 8'h00);
        pins();
        give_verdict();
    end
endmodule : tb
